// *** include/cbfl_map.svh ***
`ifndef CBFL_MAP_SVH
`define CBFL_MAP_SVH

// Address regions, PADDR[11:8]
`define CBFL_REGION_CTRL 4'h0
`define CBFL_REGION_GPR  4'h1
`define CBFL_REGION_IO   4'h2
// Data memory window, PADDR[11:10]
`define CBFL_DMEM_SEL    2'h1

// Control register byte offsets inside the control region
`define CBFL_OFF_CMD     8'h00
`define CBFL_OFF_STAT    8'h04
`define CBFL_OFF_STATUS  8'h08
`define CBFL_OFF_PC      8'h0C

// Command word fields
`define CBFL_F_OP_HI     5
`define CBFL_F_OP_LO     0
`define CBFL_F_RD_HI     10
`define CBFL_F_RD_LO     6
`define CBFL_F_RR_HI     15
`define CBFL_F_RR_LO     11
`define CBFL_F_BIT_HI    18
`define CBFL_F_BIT_LO    16
`define CBFL_F_IMM_HI    26
`define CBFL_F_IMM_LO    19
`define CBFL_F_PTR_SEL   27

// Status register bit positions
`define CBFL_FLAG_C      0
`define CBFL_FLAG_Z      1
`define CBFL_FLAG_N      2
`define CBFL_FLAG_V      3
`define CBFL_FLAG_S      4
`define CBFL_FLAG_H      5
`define CBFL_FLAG_T      6
`define CBFL_FLAG_I      7

// Pointer register pairs in the working register file
`define CBFL_PTR_X_LO    5'h1A
`define CBFL_PTR_X_HI    5'h1B
`define CBFL_PTR_Y_LO    5'h1C
`define CBFL_PTR_Y_HI    5'h1D

// Reset values
`define CBFL_RST_STATUS  8'h00
`define CBFL_RST_PC      16'h0000
`define CBFL_RST_BYTE    8'h00
`define CBFL_RST_CMD     32'h0000_0000

// Execution cycle counts
`define CBFL_CYC_NONE    2'h0
`define CBFL_CYC_ONE     2'h1
`define CBFL_CYC_TWO     2'h2

`endif

// *** include/cbfl_pkg.sv ***
package cbfl_pkg;

	typedef enum logic [5:0] {
		OP_NOP,
		OP_BRANCH_ON_IRQ_ENABLED,
		OP_BRANCH_ON_IRQ_DISABLED,
		OP_IO_BIT_SET,
		OP_IO_BIT_CLEAR,
		OP_LOGICAL_LEFT_SHIFT,
		OP_LOGICAL_RIGHT_SHIFT,
		OP_ROTATE_LEFT_CARRY,
		OP_ROTATE_RIGHT_CARRY,
		OP_ARITH_RIGHT_SHIFT,
		OP_NIBBLE_SWAP,
		OP_FLAG_SET,
		OP_FLAG_CLEAR,
		OP_BIT_TO_T_STORE,
		OP_T_TO_BIT_LOAD,
		OP_REGISTER_COPY,
		OP_REGISTER_PAIR_COPY,
		OP_IMMEDIATE_LOAD,
		OP_POINTER_LOAD,
		OP_POINTER_LOAD_INC,
		OP_POINTER_LOAD_DEC
	} cbfl_op_t;

	typedef enum logic [1:0] {
		S_IDLE,
		S_RUN1,
		S_RUN2
	} cbfl_state_t;

endpackage

// *** src/cbfl_shift.sv ***
`timescale 1ns/1ps
module cbfl_shift (
	input  wire cbfl_pkg::cbfl_op_t op,
	input  wire logic [7:0]         din,
	input  wire logic               cin,
	output logic      [7:0]         res,
	output logic                    c_out,
	output logic                    z_out,
	output logic                    n_out,
	output logic                    v_out
);
	import cbfl_pkg::*;

	always_comb begin
		res   = din;
		c_out = cin;
		unique case (op)
			OP_LOGICAL_LEFT_SHIFT: begin
				res   = {din[6:0], 1'b0};
				c_out = din[7];
			end
			OP_ROTATE_LEFT_CARRY: begin
				res   = {din[6:0], cin};
				c_out = din[7];
			end
			OP_LOGICAL_RIGHT_SHIFT: begin
				res   = {1'b0, din[7:1]};
				c_out = din[0];
			end
			OP_ROTATE_RIGHT_CARRY: begin
				res   = {cin, din[7:1]};
				c_out = din[0];
			end
			OP_ARITH_RIGHT_SHIFT: begin
				res   = {din[7], din[7:1]};
				c_out = din[0];
			end
			default: begin
				res   = din;
				c_out = cin;
			end
		endcase
		z_out = (res == 8'h00);
		n_out = res[7];
		v_out = res[7] ^ c_out;
	end

endmodule // cbfl_shift

// *** src/cbfl_dmem.sv ***
`timescale 1ns/1ps
module cbfl_dmem (
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic       we,
	input  wire logic [7:0] waddr,
	input  wire logic [7:0] wdata,
	input  wire logic [7:0] raddr,
	output logic      [7:0] rdata
);
	logic [7:0] mem [0:255];

	always_ff @(posedge clk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
	end

	// Registered read, one cycle after the address
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata <= 8'h00;
		end else begin
			rdata <= mem[raddr];
		end
	end

endmodule // cbfl_dmem

// *** src/cbfl_core.sv ***
// Notes on behaviour
// - Branch when I is 1 adds offset plus one; one cycle, two if taken.
// - Branch when I is 0 adds offset plus one; one cycle, two if taken.
// - I/O bit set forces chosen bit to 1, flags untouched, two cycles.
// - I/O bit clear forces chosen bit to 0, flags untouched, two cycles.
// - Left rotate through carry, left shift fills zero; one cycle, updates Z C N V.
// - Right rotate through carry, logical and arithmetic shifts; one cycle, Z C N V.
// - Bit store copies a register bit into T in one cycle.
// - Bit load copies T into a register bit, flags untouched, one cycle.
// - Sign set drives S to 1 in one cycle.
// - Sign clear drives S to 0 in one cycle, other flags unchanged.
// - Overflow set forces V to 1 in one cycle.
// - Overflow clear forces V to 0 in one cycle.
// - Half carry set forces H to 1 in one cycle.
// - Half carry clear forces H to 0 in one cycle.
// - Post-increment load reads at pointer, then pointer plus one; two cycles.
// - Pre-decrement load lowers pointer, then reads new address; two cycles.
//
// The address map and the APB slave port were chosen for this implementation.
`timescale 1ns/1ps
`include "cbfl_map.svh"
module cbfl_core (
	input  wire logic        MCLK,
	input  wire logic        RESETN,
	input  wire logic        PSEL,
	input  wire logic        PENABLE,
	input  wire logic        PWRITE,
	input  wire logic [11:0] PADDR,
	input  wire logic [31:0] PWDATA,
	output logic      [31:0] PRDATA,
	output logic             PREADY,
	output logic             PSLVERR
);
	import cbfl_pkg::*;

	logic [7:0]  gpr_r [0:31];
	logic [7:0]  io_r  [0:31];
	logic [7:0]  status_r;
	logic [15:0] pc_r;
	logic [31:0] cmd_r;
	cbfl_state_t state_r;
	logic [1:0]  cycles_r;
	logic        err_r;
	logic        addr_ok_r;
	logic        pready_r;
	logic [31:0] prdata_r;
	logic        pslverr_r;

	cbfl_op_t    op;
	logic [4:0]  rd;
	logic [4:0]  rr;
	logic [2:0]  bsel;
	logic [7:0]  imm;
	logic        ptr_y;
	logic [4:0]  ptr_lo_idx;
	logic [4:0]  ptr_hi_idx;
	logic [15:0] ptr;
	logic [15:0] ptr_inc;
	logic [15:0] ptr_dec;
	logic [15:0] pc_inc;
	logic [15:0] pc_target;
	logic [7:0]  rd_val;
	logic [7:0]  rr_val;
	logic        busy;
	logic        taken;
	logic        is_io_op;
	logic        is_load;
	logic        multi;
	logic        legal;

	logic [7:0]  sh_res;
	logic        sh_c;
	logic        sh_z;
	logic        sh_n;
	logic        sh_v;
	logic [7:0]  mem_q;
	logic [7:0]  mem_raddr;
	logic [7:0]  exec_addr;

	logic        apb_access;
	logic        fire;
	logic        wr_fire;
	logic        sel_cmd;
	logic        sel_stat;
	logic        sel_status;
	logic        sel_pc;
	logic        sel_gpr;
	logic        sel_io;
	logic        sel_dmem;
	logic        hit;
	logic [31:0] rdata;
	logic        start;

	// Command decode
	assign op         = cbfl_op_t'(cmd_r[`CBFL_F_OP_HI:`CBFL_F_OP_LO]);
	assign rd         = cmd_r[`CBFL_F_RD_HI:`CBFL_F_RD_LO];
	assign rr         = cmd_r[`CBFL_F_RR_HI:`CBFL_F_RR_LO];
	assign bsel       = cmd_r[`CBFL_F_BIT_HI:`CBFL_F_BIT_LO];
	assign imm        = cmd_r[`CBFL_F_IMM_HI:`CBFL_F_IMM_LO];
	assign ptr_y      = cmd_r[`CBFL_F_PTR_SEL];
	assign ptr_lo_idx = ptr_y ? `CBFL_PTR_Y_LO : `CBFL_PTR_X_LO;
	assign ptr_hi_idx = ptr_y ? `CBFL_PTR_Y_HI : `CBFL_PTR_X_HI;
	assign ptr        = {gpr_r[ptr_hi_idx], gpr_r[ptr_lo_idx]};
	assign ptr_inc    = ptr + 16'h0001;
	assign ptr_dec    = ptr - 16'h0001;
	assign pc_inc     = pc_r + 16'h0001;
	// Seven-bit signed offset, plus one
	assign pc_target  = pc_inc + {{9{imm[6]}}, imm[6:0]};
	assign rd_val     = gpr_r[rd];
	assign rr_val     = gpr_r[rr];
	assign busy       = (state_r != S_IDLE);

	assign taken = ((op == OP_BRANCH_ON_IRQ_ENABLED) && status_r[`CBFL_FLAG_I])
	            || ((op == OP_BRANCH_ON_IRQ_DISABLED) && !status_r[`CBFL_FLAG_I]);
	assign is_io_op = (op == OP_IO_BIT_SET) || (op == OP_IO_BIT_CLEAR);
	assign is_load  = (op == OP_POINTER_LOAD) || (op == OP_POINTER_LOAD_INC)
	               || (op == OP_POINTER_LOAD_DEC);
	assign multi    = taken || is_io_op || is_load;
	assign legal    = (cmd_r[`CBFL_F_OP_HI:`CBFL_F_OP_LO] <= 6'(OP_POINTER_LOAD_DEC));

	// Pre-decrement reads the already lowered address
	assign exec_addr = (op == OP_POINTER_LOAD_DEC) ? ptr_dec[7:0] : ptr[7:0];
	assign mem_raddr = busy ? exec_addr : PADDR[9:2];

	cbfl_shift u_shift (
		.op    (op),
		.din   (rd_val),
		.cin   (status_r[`CBFL_FLAG_C]),
		.res   (sh_res),
		.c_out (sh_c),
		.z_out (sh_z),
		.n_out (sh_n),
		.v_out (sh_v)
	);

	cbfl_dmem u_dmem (
		.clk   (MCLK),
		.rst_n (RESETN),
		.we    (wr_fire && sel_dmem),
		.waddr (PADDR[9:2]),
		.wdata (PWDATA[7:0]),
		.raddr (mem_raddr),
		.rdata (mem_q)
	);

	// APB decode and read mux
	assign apb_access = PSEL && PENABLE;
	assign fire       = apb_access && pready_r;
	assign wr_fire    = fire && PWRITE;
	assign start      = wr_fire && sel_cmd;

	always_comb begin
		sel_cmd    = 1'b0;
		sel_stat   = 1'b0;
		sel_status = 1'b0;
		sel_pc     = 1'b0;
		sel_gpr    = 1'b0;
		sel_io     = 1'b0;
		sel_dmem   = 1'b0;
		rdata      = 32'h0000_0000;
		if (PADDR[1:0] == 2'b00) begin
			if (PADDR[11:8] == `CBFL_REGION_CTRL) begin
				sel_cmd    = (PADDR[7:0] == `CBFL_OFF_CMD);
				sel_stat   = (PADDR[7:0] == `CBFL_OFF_STAT);
				sel_status = (PADDR[7:0] == `CBFL_OFF_STATUS);
				sel_pc     = (PADDR[7:0] == `CBFL_OFF_PC);
			end else if (PADDR[11:8] == `CBFL_REGION_GPR) begin
				sel_gpr = !PADDR[7];
			end else if (PADDR[11:8] == `CBFL_REGION_IO) begin
				sel_io = !PADDR[7];
			end else if (PADDR[11:10] == `CBFL_DMEM_SEL) begin
				sel_dmem = 1'b1;
			end
		end
		if (sel_cmd) begin
			rdata = cmd_r;
		end else if (sel_stat) begin
			rdata = {28'h000_0000, err_r, cycles_r, busy};
		end else if (sel_status) begin
			rdata = {24'h00_0000, status_r};
		end else if (sel_pc) begin
			rdata = {16'h0000, pc_r};
		end else if (sel_gpr) begin
			rdata = {24'h00_0000, gpr_r[PADDR[6:2]]};
		end else if (sel_io) begin
			rdata = {24'h00_0000, io_r[PADDR[6:2]]};
		end else if (sel_dmem) begin
			rdata = {24'h00_0000, mem_q};
		end
		hit = sel_cmd || sel_stat || sel_status || sel_pc || sel_gpr || sel_io || sel_dmem;
	end

	// Memory read data matches PADDR once the address has stood one idle cycle
	always_ff @(posedge MCLK or negedge RESETN) begin
		if (!RESETN) begin
			addr_ok_r <= 1'b0;
		end else begin
			addr_ok_r <= PSEL && !busy;
		end
	end

	// Accesses stall while an instruction runs
	always_ff @(posedge MCLK or negedge RESETN) begin
		if (!RESETN) begin
			pready_r  <= 1'b0;
			prdata_r  <= 32'h0000_0000;
			pslverr_r <= 1'b0;
		end else if (apb_access && !pready_r && !busy && addr_ok_r) begin
			pready_r  <= 1'b1;
			prdata_r  <= PWRITE ? 32'h0000_0000 : rdata;
			pslverr_r <= !hit;
		end else begin
			pready_r  <= 1'b0;
			prdata_r  <= 32'h0000_0000;
			pslverr_r <= 1'b0;
		end
	end

	assign PREADY  = pready_r;
	assign PRDATA  = prdata_r;
	assign PSLVERR = pslverr_r;

	// Sequencer
	always_ff @(posedge MCLK or negedge RESETN) begin
		if (!RESETN) begin
			state_r  <= S_IDLE;
			cmd_r    <= `CBFL_RST_CMD;
			cycles_r <= `CBFL_CYC_NONE;
			err_r    <= 1'b0;
		end else begin
			unique case (state_r)
				S_IDLE: begin
					if (start) begin
						cmd_r   <= PWDATA;
						state_r <= S_RUN1;
					end
				end
				S_RUN1: begin
					err_r <= !legal;
					if (multi) begin
						state_r <= S_RUN2;
					end else begin
						state_r  <= S_IDLE;
						cycles_r <= `CBFL_CYC_ONE;
					end
				end
				S_RUN2: begin
					state_r  <= S_IDLE;
					cycles_r <= `CBFL_CYC_TWO;
				end
			endcase
		end
	end

	// Program counter
	always_ff @(posedge MCLK or negedge RESETN) begin
		if (!RESETN) begin
			pc_r <= `CBFL_RST_PC;
		end else if (wr_fire && sel_pc) begin
			pc_r <= PWDATA[15:0];
		end else if (state_r == S_RUN1) begin
			if (taken) begin
				pc_r <= pc_target;
			end else if (!multi) begin
				pc_r <= pc_inc;
			end
		end else if ((state_r == S_RUN2) && !taken) begin
			pc_r <= pc_inc;
		end
	end

	// Status register
	always_ff @(posedge MCLK or negedge RESETN) begin
		if (!RESETN) begin
			status_r <= `CBFL_RST_STATUS;
		end else if (wr_fire && sel_status) begin
			status_r <= PWDATA[7:0];
		end else if (state_r == S_RUN1) begin
			unique case (op)
				OP_LOGICAL_LEFT_SHIFT, OP_LOGICAL_RIGHT_SHIFT, OP_ROTATE_LEFT_CARRY,
				OP_ROTATE_RIGHT_CARRY, OP_ARITH_RIGHT_SHIFT: begin
					status_r[`CBFL_FLAG_C] <= sh_c;
					status_r[`CBFL_FLAG_Z] <= sh_z;
					status_r[`CBFL_FLAG_N] <= sh_n;
					status_r[`CBFL_FLAG_V] <= sh_v;
				end
				OP_FLAG_SET: begin
					status_r[bsel] <= 1'b1;
				end
				OP_FLAG_CLEAR: begin
					status_r[bsel] <= 1'b0;
				end
				OP_BIT_TO_T_STORE: begin
					status_r[`CBFL_FLAG_T] <= rr_val[bsel];
				end
				default: begin
					status_r <= status_r;
				end
			endcase
		end
	end

	// Working registers
	always_ff @(posedge MCLK or negedge RESETN) begin
		if (!RESETN) begin
			for (int i = 0; i < 32; i++) begin
				gpr_r[i] <= `CBFL_RST_BYTE;
			end
		end else if (wr_fire && sel_gpr) begin
			gpr_r[PADDR[6:2]] <= PWDATA[7:0];
		end else if (state_r == S_RUN1) begin
			unique case (op)
				OP_LOGICAL_LEFT_SHIFT, OP_LOGICAL_RIGHT_SHIFT, OP_ROTATE_LEFT_CARRY,
				OP_ROTATE_RIGHT_CARRY, OP_ARITH_RIGHT_SHIFT: begin
					gpr_r[rd] <= sh_res;
				end
				OP_NIBBLE_SWAP: begin
					gpr_r[rd] <= {rd_val[3:0], rd_val[7:4]};
				end
				OP_REGISTER_COPY: begin
					gpr_r[rd] <= rr_val;
				end
				OP_REGISTER_PAIR_COPY: begin
					gpr_r[{rd[4:1], 1'b0}] <= gpr_r[{rr[4:1], 1'b0}];
					gpr_r[{rd[4:1], 1'b1}] <= gpr_r[{rr[4:1], 1'b1}];
				end
				OP_IMMEDIATE_LOAD: begin
					gpr_r[rd] <= imm;
				end
				OP_T_TO_BIT_LOAD: begin
					gpr_r[rd][bsel] <= status_r[`CBFL_FLAG_T];
				end
				OP_POINTER_LOAD_INC: begin
					gpr_r[ptr_lo_idx] <= ptr_inc[7:0];
					gpr_r[ptr_hi_idx] <= ptr_inc[15:8];
				end
				OP_POINTER_LOAD_DEC: begin
					gpr_r[ptr_lo_idx] <= ptr_dec[7:0];
					gpr_r[ptr_hi_idx] <= ptr_dec[15:8];
				end
				default: begin
					gpr_r[rd] <= rd_val;
				end
			endcase
		end else if ((state_r == S_RUN2) && is_load) begin
			gpr_r[rd] <= mem_q;
		end
	end

	// I/O registers
	always_ff @(posedge MCLK or negedge RESETN) begin
		if (!RESETN) begin
			for (int i = 0; i < 32; i++) begin
				io_r[i] <= `CBFL_RST_BYTE;
			end
		end else if (wr_fire && sel_io) begin
			io_r[PADDR[6:2]] <= PWDATA[7:0];
		end else if (state_r == S_RUN2) begin
			if (op == OP_IO_BIT_SET) begin
				io_r[rr][bsel] <= 1'b1;
			end else if (op == OP_IO_BIT_CLEAR) begin
				io_r[rr][bsel] <= 1'b0;
			end
		end
	end

endmodule // cbfl_core

// *** tb/cbfl_core_asserts.sv ***
`timescale 1ns/1ps
module cbfl_core_asserts (
	input  wire logic        MCLK,
	input  wire logic        RESETN,
	input  wire logic        PSEL,
	input  wire logic        PENABLE,
	input  wire logic        PWRITE,
	input  wire logic [11:0] PADDR,
	input  wire logic [31:0] PWDATA,
	input  wire logic [31:0] PRDATA,
	input  wire logic        PREADY,
	input  wire logic        PSLVERR
);
	default clocking cb @(posedge MCLK); endclocking
	default disable iff (!RESETN);
	chk_ready_in_access: assert property (PREADY |-> PSEL && PENABLE)
		else $error("Ready seen outside an access phase");
	chk_ready_one_pulse: assert property (PREADY |=> !PREADY)
		else $error("Ready held longer than one cycle");
	chk_ready_not_early: assert property (PSEL && $rose(PENABLE) |-> !PREADY)
		else $error("Ready in first access cycle");
	chk_ready_bounded: assert property (PSEL && $rose(PENABLE) |-> ##[1:8] PREADY)
		else $error("Ready did not arrive in time");
	chk_err_with_ready: assert property (PSLVERR |-> PREADY && PRDATA == 32'h0000_0000)
		else $error("Error flag without ready or with data");
	chk_rdata_quiet: assert property (!PREADY || PWRITE |-> PRDATA == 32'h0000_0000)
		else $error("Read data driven outside a read answer");
	chk_misalign_err: assert property (PREADY && PADDR[1:0] != 2'b00 |-> PSLVERR)
		else $error("Misaligned access not flagged");
	chk_unmapped_err: assert property (PREADY && PADDR[11:8] == 4'h3 |-> PSLVERR)
		else $error("Unmapped access not flagged");
	chk_gpr_no_err: assert property (PREADY && PADDR[11:7] == 5'h02 && PADDR[1:0] == 2'b00
		|-> !PSLVERR)
		else $error("Working register access flagged");
endmodule // cbfl_core_asserts

// *** tb/cpu_bit_flag_load_ops_test.sv ***
`timescale 1ns/1ps
module cpu_bit_flag_load_ops_test;
	logic        MCLK = 1'b0;
	logic        RESETN = 1'b0;
	logic        PSEL = 1'b0;
	logic        PENABLE = 1'b0;
	logic        PWRITE = 1'b0;
	logic [11:0] PADDR = 12'h000;
	logic [31:0] PWDATA = 32'h0000_0000;
	logic [31:0] PRDATA;
	logic        PREADY;
	logic        PSLVERR;
	int          errors = 0;
	int          total_checks = 0;
	logic [31:0] d;
	logic        e;
	cbfl_core dut (.MCLK(MCLK), .RESETN(RESETN), .PSEL(PSEL), .PENABLE(PENABLE),
		.PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
		.PREADY(PREADY), .PSLVERR(PSLVERR));
	initial begin
		forever #5 MCLK = ~MCLK;
	end
	task automatic conclude;
		if (errors == 0 && total_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// Request held until ready is sampled high, then released
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] wd);
		int n;
		PSEL <= 1'b1;
		PWRITE <= w;
		PADDR <= a;
		PWDATA <= wd;
		@(posedge MCLK);
		PENABLE <= 1'b1;
		n = 0;
		do begin
			@(posedge MCLK);
			n++;
		end while (PREADY !== 1'b1 && n < 40);
		d = PRDATA;
		e = PSLVERR;
		PSEL <= 1'b0;
		PENABLE <= 1'b0;
		if (PREADY !== 1'b1) begin
			chk(32'(PREADY), 32'h0000_0001);
			conclude();
		end
		@(posedge MCLK);
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] v);
		xfer(1'b1, a, v);
	endtask
	task automatic rc(input logic [11:0] a, input logic [31:0] exp);
		xfer(1'b0, a, 32'h0000_0000);
		chk(d, exp);
	endtask
	function automatic logic [11:0] ra(input logic [11:0] base, input int n);
		return base + 12'(n * 4);
	endfunction
	function automatic logic [31:0] cw(input int op, input int dst, input int rr,
		input int b, input int k, input int p);
		return {4'h0, p[0], k[7:0], b[2:0], rr[4:0], dst[4:0], op[5:0]};
	endfunction
	// Status read stalls until the instruction is done
	task automatic run(input logic [31:0] w, input logic [1:0] cy);
		wr(12'h000, w);
		rc(12'h004, 32'({cy, 1'b0}));
		chk(32'(e), 32'h0000_0000);
	endtask
	task automatic t_reset;
		rc(12'h008, 32'h0000_0000);
		rc(12'h00C, 32'h0000_0000);
		rc(ra(12'h100, 31), 32'h0000_0000);
	endtask
	task automatic t_branch;
		int op;
		int i;
		logic tk;
		for (op = 1; op <= 2; op++) begin
			for (i = 0; i < 2; i++) begin
				tk = (op == 1) == (i == 1);
				wr(12'h008, i ? 32'h0000_0080 : 32'h0000_0000);
				wr(12'h00C, 32'h0000_0010);
				run(cw(op, 0, 0, 0, 8'h7D, 0), tk ? 2'h2 : 2'h1);
				rc(12'h00C, tk ? 32'h0000_000E : 32'h0000_0011);
			end
		end
	endtask
	task automatic t_iobit;
		wr(12'h008, 32'h0000_003C);
		wr(ra(12'h200, 5), 32'h0000_00A5);
		run(cw(3, 0, 5, 1, 0, 0), 2'h2);
		rc(ra(12'h200, 5), 32'h0000_00A7);
		run(cw(4, 0, 5, 7, 0, 0), 2'h2);
		rc(ra(12'h200, 5), 32'h0000_0027);
		rc(12'h008, 32'h0000_003C);
	endtask
	task automatic t_shift;
		logic [7:0] vals [3] = '{8'h81, 8'h01, 8'h80};
		logic [7:0] v;
		logic [7:0] r;
		logic       ci;
		logic       c;
		int         op;
		int         i;
		for (op = 5; op <= 9; op++) begin
			for (i = 0; i < 3; i++) begin
				v = vals[i];
				ci = i[0];
				case (op)
					5: {c, r} = {v, 1'b0};
					6: {r, c} = {1'b0, v};
					7: {c, r} = {v, ci};
					8: {r, c} = {ci, v};
					default: {r, c} = {v[7], v};
				endcase
				wr(ra(12'h100, 9), 32'(v));
				wr(12'h008, 32'({7'h50, ci}));
				run(cw(op, 9, 9, 0, 0, 0), 2'h1);
				rc(ra(12'h100, 9), 32'(r));
				rc(12'h008, 32'({4'hA, r[7] ^ c, r[7], r == 8'h00, c}));
			end
		end
	endtask
	task automatic t_tbit;
		wr(12'h008, 32'h0000_0021);
		wr(ra(12'h100, 3), 32'h0000_0008);
		wr(ra(12'h100, 4), 32'h0000_0081);
		run(cw(13, 3, 3, 3, 0, 0), 2'h1);
		rc(12'h008, 32'h0000_0061);
		run(cw(14, 4, 4, 6, 0, 0), 2'h1);
		rc(ra(12'h100, 4), 32'h0000_00C1);
		rc(12'h008, 32'h0000_0061);
		run(cw(13, 3, 3, 0, 0, 0), 2'h1);
		rc(12'h008, 32'h0000_0021);
	endtask
	task automatic t_flags;
		logic [7:0] m;
		int         s;
		for (s = 0; s < 8; s++) begin
			m = 8'h01 << s;
			wr(12'h008, 32'h0000_0000);
			run(cw(11, 0, 0, s, 0, 0), 2'h1);
			rc(12'h008, 32'(m));
			m = ~m;
			wr(12'h008, 32'h0000_00FF);
			run(cw(12, 0, 0, s, 0, 0), 2'h1);
			rc(12'h008, 32'(m));
		end
	endtask
	task automatic t_moves;
		wr(12'h008, 32'h0000_005A);
		wr(ra(12'h100, 2), 32'h0000_0012);
		wr(ra(12'h100, 3), 32'h0000_0034);
		wr(ra(12'h100, 7), 32'h0000_00C3);
		run(cw(15, 1, 2, 0, 0, 0), 2'h1);
		run(cw(16, 4, 2, 0, 0, 0), 2'h1);
		run(cw(17, 6, 0, 0, 8'h9E, 0), 2'h1);
		run(cw(10, 7, 7, 0, 0, 0), 2'h1);
		rc(ra(12'h100, 1), 32'h0000_0012);
		rc(ra(12'h100, 4), 32'h0000_0012);
		rc(ra(12'h100, 5), 32'h0000_0034);
		rc(ra(12'h100, 6), 32'h0000_009E);
		rc(ra(12'h100, 7), 32'h0000_003C);
		rc(12'h008, 32'h0000_005A);
	endtask
	task automatic t_ptr;
		wr(12'h008, 32'h0000_0000);
		wr(ra(12'h400, 16), 32'h0000_005A);
		wr(ra(12'h400, 255), 32'h0000_0077);
		wr(ra(12'h400, 17), 32'h0000_00C6);
		rc(ra(12'h400, 16), 32'h0000_005A);
		wr(ra(12'h100, 26), 32'h0000_0010);
		wr(ra(12'h100, 27), 32'h0000_0000);
		wr(ra(12'h100, 28), 32'h0000_0000);
		wr(ra(12'h100, 29), 32'h0000_0001);
		run(cw(19, 2, 0, 0, 0, 0), 2'h2);
		rc(ra(12'h100, 2), 32'h0000_005A);
		rc(ra(12'h100, 26), 32'h0000_0011);
		// Plain load leaves the pointer where it was
		run(cw(18, 4, 0, 0, 0, 0), 2'h2);
		rc(ra(12'h100, 4), 32'h0000_00C6);
		rc(ra(12'h100, 26), 32'h0000_0011);
		// Borrow across the pointer pair
		run(cw(20, 3, 0, 0, 0, 1), 2'h2);
		rc(ra(12'h100, 3), 32'h0000_0077);
		rc(ra(12'h100, 28), 32'h0000_00FF);
		rc(ra(12'h100, 29), 32'h0000_0000);
		rc(12'h008, 32'h0000_0000);
	endtask
	task automatic t_err;
		rc(12'h002, 32'h0000_0000);
		chk(32'(e), 32'h0000_0001);
		wr(12'h300, 32'h0000_00FF);
		chk(32'(e), 32'h0000_0001);
		rc(12'h300, 32'h0000_0000);
		wr(12'h00C, 32'h0000_0040);
		wr(12'h000, cw(21, 0, 0, 0, 0, 0));
		rc(12'h004, 32'h0000_000A);
		rc(12'h00C, 32'h0000_0041);
		// No-op clears the illegal flag and still steps the counter
		run(cw(0, 0, 0, 0, 0, 0), 2'h1);
		rc(12'h00C, 32'h0000_0042);
		// Status word is read only, a write is dropped without error
		wr(12'h004, 32'h0000_000F);
		chk(32'(e), 32'h0000_0000);
		rc(12'h004, 32'h0000_0002);
	endtask
	initial begin
		repeat (2) @(posedge MCLK);
		RESETN <= 1'b1;
		@(posedge MCLK);
		t_reset();
		t_branch();
		t_iobit();
		t_shift();
		t_tbit();
		t_flags();
		t_moves();
		t_ptr();
		t_err();
		conclude();
	end
endmodule // cpu_bit_flag_load_ops_test
bind cbfl_core cbfl_core_asserts u_chk (.MCLK(MCLK), .RESETN(RESETN), .PSEL(PSEL),
	.PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
	.PREADY(PREADY), .PSLVERR(PSLVERR));
